// ### pkg/stp_pkg.sv
// Package: register map, field layout and clock-select codes of the shared timer prescaler
package stp_pkg;
	// APB widths
	localparam int unsigned STP_AW = 8;
	localparam int unsigned STP_DW = 32;
	// Register indices; the byte address on APB is four times the index
	localparam logic [7:0] STP_IDX_GTC    = 8'h23;
	localparam logic [7:0] STP_IDX_SEL    = 8'h24;
	localparam logic [7:0] STP_IDX_STATUS = 8'h25;
	localparam logic [7:0] STP_ADDR_GTC    = {STP_IDX_GTC[5:0], 2'h0};
	localparam logic [7:0] STP_ADDR_SEL    = {STP_IDX_SEL[5:0], 2'h0};
	localparam logic [7:0] STP_ADDR_STATUS = {STP_IDX_STATUS[5:0], 2'h0};
	// Field positions of general_timer_control
	localparam int unsigned STP_SYNC_HOLD_MODE_BIT  = 7;
	localparam int unsigned STP_PRESCALER_RESET_BIT = 0;
	// Field positions of the clock select register
	localparam int unsigned STP_SEL_T0_LSB = 0;
	localparam int unsigned STP_SEL_T1_LSB = 4;
	localparam int unsigned STP_SEL_W      = 3;
	// Reset values
	localparam logic [7:0] STP_GTC_RESET = 8'h00;
	localparam logic [2:0] STP_SEL_RESET = 3'h0;
	// Prescaler counter and its taps: bits below each tap (divide by 8, 64, 256, 1024)
	localparam int unsigned STP_PRE_W     = 10;
	localparam int unsigned STP_TAP8_W    = 3;
	localparam int unsigned STP_TAP64_W   = 6;
	localparam int unsigned STP_TAP256_W  = 8;
	localparam int unsigned STP_TAP1024_W = 10;
	localparam int unsigned STP_NUM_TAPS  = 4;
	localparam int unsigned STP_NUM_TIMERS = 2;
	// Clock-select codes of each timer
	typedef enum logic [2:0] {
		STP_CS_STOP     = 3'h0,
		STP_CS_DIRECT   = 3'h1,
		STP_CS_DIV8     = 3'h2,
		STP_CS_DIV64    = 3'h3,
		STP_CS_DIV256   = 3'h4,
		STP_CS_DIV1024  = 3'h5,
		STP_CS_EXT_FALL = 3'h6,
		STP_CS_EXT_RISE = 3'h7
	} stp_clock_select_field_e;
	// Layout of general_timer_control
	typedef struct packed {
		logic       sync_hold_mode;
		logic [5:0] reserved;
		logic       prescaler_reset;
	} stp_general_timer_control_s;
	// Prescaler count
	typedef logic [STP_PRE_W-1:0] stp_count_t;
endpackage

// ### hdl/stp_pin_sync.sv
// External clock pin synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module stp_pin_sync
	import stp_pkg::*;
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	// External clock pin, read whatever its direction
	input  wire logic i_pin,
	// One-cycle edge pulses
	output logic      o_rise,
	output logic      o_fall
);
	logic       latch_q;
	logic       s1_r;
	logic       s2_r;
	logic       s3_r;
	logic       lvl_r;
	logic [3:0] fill_r;
	logic       agree;

	// Latch open while the clock is high, so the pin is caught half a cycle early
	always_latch begin
		if (!i_rst_b) begin
			latch_q <= 1'b0;
		end else if (i_clk) begin
			latch_q <= i_pin;
		end
	end

	// Three flops sample the latch once per clock
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= latch_q;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Stages hold reset zeros, not the pin, for a few clocks; a pin idling high
	// would otherwise look like a rising edge straight after reset
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fill_r <= 4'h0;
		end else begin
			fill_r <= {fill_r[2:0], 1'b1};
		end
	end

	// A level counts once the second and third stages agree
	assign agree = (s2_r == s3_r);

	// Accepted level; pulses too fast for the sampler simply merge
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lvl_r <= 1'b0;
		end else if (!fill_r[3] || agree) begin
			lvl_r <= s3_r;
		end
	end

	// One pulse per accepted edge
	assign o_rise = fill_r[3] && agree && s3_r && !lvl_r;
	assign o_fall = fill_r[3] && agree && !s3_r && lvl_r;

	a_edge_single: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_rise || o_fall) |=> !(o_rise || o_fall))
		else $error("edge pulse lasted more than one cycle");
endmodule
`default_nettype wire

// ### hdl/stp_tap_sel.sv
// Per-timer clock-source selector over the shared prescaler taps and pin edges
`timescale 1ns/1ps
`default_nettype none
module stp_tap_sel
	import stp_pkg::*;
(
	// Clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_rst_b,
	// Source selection and sources
	input  wire stp_clock_select_field_e i_sel,
	input  wire stp_count_t              i_count,
	input  wire logic                    i_halt,
	input  wire logic                    i_rise,
	input  wire logic                    i_fall,
	// Count enable toward the timer
	output logic                         o_count_pulse
);
	logic [STP_NUM_TAPS-1:0] tap_tick;
	logic                    pulse_nxt;

	// A tap ticks when all bits below it are ones; held off while the prescaler is reset
	for (genvar g = 0; g < STP_NUM_TAPS; g++) begin : g_tap
		localparam int unsigned W = (g == 0) ? STP_TAP8_W : (g == 1) ? STP_TAP64_W :
			(g == 2) ? STP_TAP256_W : STP_TAP1024_W;
		assign tap_tick[g] = !i_halt && (&i_count[W-1:0]);
	end

	// Source mux; pin edges bypass the divider entirely
	always_comb begin
		unique case (i_sel)
			STP_CS_STOP:     pulse_nxt = 1'b0;
			STP_CS_DIRECT:   pulse_nxt = 1'b1;
			STP_CS_DIV8:     pulse_nxt = tap_tick[0];
			STP_CS_DIV64:    pulse_nxt = tap_tick[1];
			STP_CS_DIV256:   pulse_nxt = tap_tick[2];
			STP_CS_DIV1024:  pulse_nxt = tap_tick[3];
			STP_CS_EXT_FALL: pulse_nxt = i_fall;
			STP_CS_EXT_RISE: pulse_nxt = i_rise;
		endcase
	end

	// Registered count enable
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_count_pulse <= 1'b0;
		end else begin
			o_count_pulse <= pulse_nxt;
		end
	end

	a_stop_no_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_sel == STP_CS_STOP |=> !o_count_pulse)
		else $error("stopped timer received a count pulse");
	a_direct_every_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_sel == STP_CS_DIRECT |=> o_count_pulse)
		else $error("direct clock missed a cycle");
	a_div8_tick: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_sel == STP_CS_DIV8 && !i_halt && i_count[2:0] == 3'h7) |=> o_count_pulse)
		else $error("divide-by-8 tap missed");
	a_ext_direct: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_sel == STP_CS_EXT_RISE) |=> (o_count_pulse == $past(i_rise)))
		else $error("rising pin edge did not pass straight through");
endmodule
`default_nettype wire

// ### hdl/stp_top.sv
// Shared timer prescaler: APB registers, free-running prescaler, per-timer clock sources
//
// Functional notes
// - Select 1 counts every system clock
// - Taps divide by 8, 64, 256, 1024
// - One prescaler, separate select per timer
// - Prescaler runs free, only reset alters it
// - First divided count within 1..N+1 clocks
// - Prescaler reset restarts both timers' periods
// - Each pin sampled once per clock
// - Sampling: high-transparent latch, then rising flops
// - Select 7 counts rising, 6 falling edges
// - Pin edge reaches counter after synchroniser delay
// - Pin edges bypass the prescaler divider
// - Sync-hold mode keeps prescaler reset asserted
// - Clearing sync-hold clears prescaler reset
// - Prescaler reset bit self-clears unless holding
// - Control bits 6:1 read as zero
// - Select 0 gives no count pulses
// - Pin counts even when driven as output
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module stp_top
	import stp_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst_b,
	// APB slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [STP_AW-1:0] i_paddr,
	input  wire logic [STP_DW-1:0] i_pwdata,
	output logic                   o_pready,
	output logic [STP_DW-1:0]      o_prdata,
	output logic                   o_pslverr,
	// External timer clock pins
	input  wire logic              i_timer0_ext_clock_pin,
	input  wire logic              i_timer1_ext_clock_pin,
	// Count enables to the two timers
	output logic                   o_timer0_count_pulse,
	output logic                   o_timer1_count_pulse
);
	stp_general_timer_control_s                        gtc_r;
	stp_clock_select_field_e [STP_NUM_TIMERS-1:0]      sel_r;
	stp_count_t                                        count_r;
	logic [STP_NUM_TIMERS-1:0]                         pin_in;
	logic [STP_NUM_TIMERS-1:0]                         pin_rise;
	logic [STP_NUM_TIMERS-1:0]                         pin_fall;
	logic [STP_NUM_TIMERS-1:0]                         count_pulse;
	logic                                              apb_setup;
	logic                                              apb_access;
	logic                                              hit_gtc;
	logic                                              hit_sel;
	logic                                              hit_status;
	logic                                              mapped;
	logic                                              wr_gtc;
	logic                                              wr_sel;
	logic [STP_DW-1:0]                                 rd_mux;
	logic [STP_DW-1:0]                                 prdata_r;
	logic                                              prescaler_hold;

	// Address decode; registers sit on aligned words only
	assign hit_gtc    = (i_paddr == STP_ADDR_GTC);
	assign hit_sel    = (i_paddr == STP_ADDR_SEL);
	assign hit_status = (i_paddr == STP_ADDR_STATUS);
	assign mapped     = hit_gtc || hit_sel || hit_status;

	// APB phases
	assign apb_setup  = i_psel && !i_penable;
	assign apb_access = i_psel && i_penable;

	// Writes land on the access edge; the status word is read-only and ignores writes
	assign wr_gtc = apb_access && i_pwrite && hit_gtc;
	assign wr_sel = apb_access && i_pwrite && hit_sel;

	// Zero wait states: every access phase completes at once
	assign o_pready = 1'b1;

	// Unmapped addresses answer with an error in the access phase
	assign o_pslverr = apb_access && !mapped;

	// General timer control: the hold bit decides whether the reset bit survives
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			gtc_r <= STP_GTC_RESET;
		end else if (wr_gtc) begin
			// A write wins over the hardware clear in the same cycle
			gtc_r.sync_hold_mode  <= i_pwdata[STP_SYNC_HOLD_MODE_BIT];
			gtc_r.prescaler_reset <= i_pwdata[STP_PRESCALER_RESET_BIT];
			gtc_r.reserved        <= '0;
		end else if (!gtc_r.sync_hold_mode) begin
			gtc_r.prescaler_reset <= 1'b0;
		end
	end

	// Prescaler reset level seen by the counter and the taps
	assign prescaler_hold = gtc_r.prescaler_reset;

	// Clock select fields, one per timer
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sel_r[0] <= stp_clock_select_field_e'(STP_SEL_RESET);
			sel_r[1] <= stp_clock_select_field_e'(STP_SEL_RESET);
		end else if (wr_sel) begin
			sel_r[0] <= stp_clock_select_field_e'(i_pwdata[STP_SEL_T0_LSB +: STP_SEL_W]);
			sel_r[1] <= stp_clock_select_field_e'(i_pwdata[STP_SEL_T1_LSB +: STP_SEL_W]);
		end
	end

	// Shared prescaler: counts every clock, whatever the timers select.
	// Only the reset bit touches it, so a restart moves both timers' phases.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count_r <= '0;
		end else if (prescaler_hold) begin
			count_r <= '0;
		end else begin
			count_r <= count_r + 1'b1;
		end
	end

	// Read mux; unused upper bits read as zero
	always_comb begin
		rd_mux = '0;
		if (hit_gtc) begin
			rd_mux[STP_SYNC_HOLD_MODE_BIT]  = gtc_r.sync_hold_mode;
			rd_mux[STP_PRESCALER_RESET_BIT] = gtc_r.prescaler_reset;
		end else if (hit_sel) begin
			rd_mux[STP_SEL_T0_LSB +: STP_SEL_W] = sel_r[0];
			rd_mux[STP_SEL_T1_LSB +: STP_SEL_W] = sel_r[1];
		end else if (hit_status) begin
			rd_mux[STP_PRE_W-1:0] = count_r;
		end
	end

	// Read data is captured in the setup phase so the access phase sees a flop.
	// The status count is therefore the value of the setup cycle.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prdata_r <= '0;
		end else if (apb_setup && !i_pwrite) begin
			prdata_r <= rd_mux;
		end
	end

	assign o_prdata = prdata_r;

	// Pins enter as plain inputs; the port direction elsewhere does not gate them
	assign pin_in[0] = i_timer0_ext_clock_pin;
	assign pin_in[1] = i_timer1_ext_clock_pin;

	// One synchroniser and one source selector per timer, sharing the prescaler
	for (genvar t = 0; t < STP_NUM_TIMERS; t++) begin : g_timer
		stp_pin_sync u_sync (
			.i_clk   (i_clk),
			.i_rst_b (i_rst_b),
			.i_pin   (pin_in[t]),
			.o_rise  (pin_rise[t]),
			.o_fall  (pin_fall[t])
		);
		stp_tap_sel u_sel (
			.i_clk         (i_clk),
			.i_rst_b       (i_rst_b),
			.i_sel         (sel_r[t]),
			.i_count       (count_r),
			.i_halt        (prescaler_hold),
			.i_rise        (pin_rise[t]),
			.i_fall        (pin_fall[t]),
			.o_count_pulse (count_pulse[t])
		);
	end

	// Timer count enables come straight from the selector flops
	assign o_timer0_count_pulse = count_pulse[0];
	assign o_timer1_count_pulse = count_pulse[1];

	// Helper for the first-count bound: clocks since timer 0 switched onto divide-by-8 or last counted, zero while the prescaler is held
	logic [3:0] div8_wait_r;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div8_wait_r <= '0;
		end else if (sel_r[0] != STP_CS_DIV8 || count_pulse[0] || prescaler_hold) begin
			div8_wait_r <= '0;
		end else if (div8_wait_r != 4'hf) begin
			div8_wait_r <= div8_wait_r + 4'h1;
		end
	end

	// The free-running counter advances by exactly one unless held
	a_presc_free: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!prescaler_hold |=> count_r == stp_count_t'($past(count_r) + 1'b1))
		else $error("prescaler did not advance by one");

	// A held reset leaves the counter at zero on the next edge
	a_presc_zeroed: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		prescaler_hold |=> count_r == '0)
		else $error("prescaler not zero after reset");

	// A one-shot reset lasts a single clock, then reads back zero
	a_reset_one_shot: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(wr_gtc && !i_pwdata[STP_SYNC_HOLD_MODE_BIT] && i_pwdata[STP_PRESCALER_RESET_BIT])
		|=> prescaler_hold ##1 !prescaler_hold)
		else $error("prescaler reset did not self-clear after one clock");

	// While holding, the reset bit stays as written
	a_hold_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(gtc_r.sync_hold_mode && prescaler_hold && !wr_gtc) |=> prescaler_hold)
		else $error("reset bit dropped while holding");

	// Leaving hold mode releases the prescaler on the next edge
	a_hold_release: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(!gtc_r.sync_hold_mode && !wr_gtc) |=> !prescaler_hold)
		else $error("reset bit survived with hold mode off");

	// Reserved control bits always read zero
	a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(apb_setup && !i_pwrite && hit_gtc) |=> o_prdata[6:1] == 6'h0)
		else $error("reserved control bits read nonzero");

	// A prescaler reset restarts the shared taps: timer 1 sees no divide-by-8 tick for seven clocks after
	a_shared_restart: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$fell(prescaler_hold) |-> (sel_r[1] != STP_CS_DIV8 || !count_pulse[1]) [*7])
		else $error("divided tick came too soon after prescaler restart");

	// On divide-by-8 the first count comes within nine clocks
	a_first_count: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		div8_wait_r <= 4'h9)
		else $error("first divided count came later than N+1 clocks");

	// Unmapped access answers with an error, mapped one without
	a_unmapped_err: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		apb_access |-> (o_pslverr == !mapped))
		else $error("slave error does not match address decode");
endmodule
`default_nettype wire

// ### test/stp_timer_model.sv
// Far-side model: two timer units counting pulses, plus an external clock source on both pins
`timescale 1ns/1ps
`default_nettype none
module stp_timer_model (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// Count enables from the prescaler
	input  wire logic        i_pulse0,
	input  wire logic        i_pulse1,
	// Source control: half period in clocks, total pin toggles wanted
	input  wire logic [3:0]  i_half,
	input  wire logic [7:0]  i_toggles,
	// Pins and timer counts
	output logic             o_pin0,
	output logic             o_pin1,
	output logic [31:0]      o_cnt0,
	output logic [31:0]      o_cnt1
);
	logic [7:0] done_r;
	logic [3:0] hcnt_r;
	// Pin1 mirrors pin0 inverted, so one toggle gives opposite edges on the two pins
	assign o_pin1 = ~o_pin0;
	// Pins move only after a full half period; idle pins stay put so mode changes see them stable
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pin0 <= 1'b0;
			done_r <= 8'h00;
			hcnt_r <= 4'h0;
		end else if (done_r == i_toggles) begin
			hcnt_r <= 4'h0;
		end else if (hcnt_r == i_half - 4'h1) begin
			o_pin0 <= ~o_pin0;
			done_r <= done_r + 8'h01;
			hcnt_r <= 4'h0;
		end else begin
			hcnt_r <= hcnt_r + 4'h1;
		end
	end
	// Timer units advance once per enable seen at a clock edge
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_cnt0 <= 32'h0000_0000;
			o_cnt1 <= 32'h0000_0000;
		end else begin
			o_cnt0 <= o_cnt0 + {31'h0, i_pulse0};
			o_cnt1 <= o_cnt1 + {31'h0, i_pulse1};
		end
	end
endmodule
`default_nettype wire

// ### test/test_shared_timer_prescaler.sv
// Self-checking bench of the shared timer prescaler against an integer model
`timescale 1ns/1ps
`default_nettype none
module test_shared_timer_prescaler;
	import stp_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  half = 4'h3;
	logic [7:0]  toggles = 8'h00;
	logic        pready, pslverr, pin0, pin1, tp0, tp1, ev;
	logic [31:0] prdata, cnt0, cnt1, rv, r1, c0, c1, d0, d1;
	logic [31:0] seed = 32'h2f39_9fb9;
	int          err_total = 0, samples_checked = 0, cyc = 0, f0, f1, k, m_gtc = 0;
	int          dv[6] = '{0, 1, 8, 64, 256, 1024};
	// 100 MHz clock
	always #5 clk = ~clk;
	// Hang guard, far above the planned run of about 16000 clocks
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			final_report();
		end
	end
	stp_top DUT (.i_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
		.i_timer0_ext_clock_pin(pin0), .i_timer1_ext_clock_pin(pin1),
		.o_timer0_count_pulse(tp0), .o_timer1_count_pulse(tp1));
	stp_timer_model partner (.i_clk(clk), .i_rst_b(rst_b), .i_pulse0(tp0), .i_pulse1(tp1), .i_half(half),
		.i_toggles(toggles), .o_pin0(pin0), .o_pin1(pin1), .o_cnt0(cnt0), .o_cnt1(cnt1));
	// Fixed-seed xorshift source
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
		end
	endtask
	// APB transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Wait as long as the slave asks; only the hang guard ends a stuck transfer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Write and keep the model's view of the control register
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rv, ev);
		if (a == STP_ADDR_GTC) begin
			m_gtc = d[7] ? int'(d & 32'h0000_0081) : int'(d & 32'h0000_0080);
		end
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic ee);
		apb(1'b0, a, 32'h0000_0000, rv, ev);
		check(nm, exp, rv);
		check("slave error", {31'h0, ee}, {31'h0, ev});
	endtask
	// Pulse counts over exactly n clock edges
	task automatic span(input int n);
		@(posedge clk);
		#1;
		c0 = cnt0;
		c1 = cnt1;
		repeat (n) @(posedge clk);
		#1;
		d0 = cnt0 - c0;
		d1 = cnt1 - c1;
	endtask
	// Edge index of the first pulse of each timer, -1 if none within the window
	task automatic firsts();
		f0 = -1;
		f1 = -1;
		for (int i = 1; i <= 1100; i++) begin
			@(posedge clk);
			#1;
			if (f0 < 0 && tp0 === 1'b1) f0 = i;
			if (f1 < 0 && tp1 === 1'b1) f1 = i;
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		// Reset values, reserved bits and an unmapped place
		rdchk("control", STP_ADDR_GTC, 32'h0000_0000, 1'b0);
		rdchk("select", STP_ADDR_SEL, 32'h0000_0000, 1'b0);
		rdchk("unmapped", 8'hfc, 32'h0000_0000, 1'b1);
		wr(STP_ADDR_GTC, 32'h0000_007e);
		rdchk("control", STP_ADDR_GTC, m_gtc, 1'b0);
		// Stopped timer 0 beside a direct-clocked timer 1
		wr(STP_ADDR_SEL, 32'h0000_0010);
		span(100);
		check("stopped count", 0, d0);
		check("direct count", 100, d1);
		// Every divided tap on timer 0, a random internal source on timer 1
		for (k = 2; k <= 5; k++) begin
			f1 = int'(xs() % 5) + 1;
			wr(STP_ADDR_SEL, 32'(k | (f1 << 4)));
			repeat (1030) @(posedge clk);
			span(2048);
			check("tap count", 2048 / dv[k], d0);
			check("other count", 2048 / dv[f1], d1);
		end
		// Two status reads three setup edges apart: the prescaler runs on regardless
		apb(1'b0, STP_ADDR_STATUS, 32'h0000_0000, r1, ev);
		apb(1'b0, STP_ADDR_STATUS, 32'h0000_0000, rv, ev);
		check("advance", 3, (rv - r1) & 32'h0000_03ff);
		// Single prescaler reset: counter restarts, bit reads back clear
		wr(STP_ADDR_GTC, 32'h0000_0001);
		apb(1'b0, STP_ADDR_STATUS, 32'h0000_0000, rv, ev);
		check("restart", 1, 32'(rv[9:0] < 10'h004));
		rdchk("control", STP_ADDR_GTC, m_gtc, 1'b0);
		// Hold mode halts both divided timers; release starts them in step
		wr(STP_ADDR_GTC, 32'h0000_0081);
		wr(STP_ADDR_SEL, 32'h0000_0032);
		rdchk("control", STP_ADDR_GTC, m_gtc, 1'b0);
		span(300);
		check("halted 0", 0, d0);
		check("halted 1", 0, d1);
		wr(STP_ADDR_GTC, 32'h0000_0000);
		firsts();
		check("start offset", 56, f1 - f0);
		check("first tick", 1, 32'(f0 >= 1 && f0 <= 12));
		rdchk("control", STP_ADDR_GTC, m_gtc, 1'b0);
		// Enabling divided taps from stop: first count within one period plus one
		wr(STP_ADDR_SEL, 32'h0000_0000);
		wr(STP_ADDR_SEL, 32'h0000_0025);
		firsts();
		check("enable delay 0", 1, 32'(f0 >= 1 && f0 <= 1025));
		check("enable delay 1", 1, 32'(f1 >= 1 && f1 <= 9));
		// Pins: timer 0 on pin0 rising, timer 1 on pin1 falling, odd toggle count
		wr(STP_ADDR_SEL, 32'h0000_0067);
		k = 2 * int'(xs() % 8) + 3;
		@(posedge clk);
		half <= 4'(2 + xs() % 4);
		toggles <= 8'(k);
		// Let this edge's timer updates settle before taking the baseline
		#1;
		c0 = cnt0;
		c1 = cnt1;
		repeat (k * 6 + 20) @(posedge clk);
		#1;
		check("rise count", (k + 1) / 2, cnt0 - c0);
		check("fall count", (k + 1) / 2, cnt1 - c1);
		// One more toggle with both on rising edges: only pin1 rises
		wr(STP_ADDR_SEL, 32'h0000_0077);
		@(posedge clk);
		toggles <= toggles + 8'h01;
		firsts();
		check("wrong edge", 32'hffff_ffff, f0);
		check("edge delay", 1, 32'(f1 - int'(half) >= 2 && f1 - int'(half) <= 6));
		final_report();
	end
endmodule
`default_nettype wire
